// [design/fach_pkg.sv]
package fach_pkg;
  // Command codes of this handler (host byte with is_cmd set)
  localparam logic [7:0] CMD_FILE_CLOSE   = 8'h01;
  localparam logic [7:0] CMD_ENTRY_FETCH  = 8'h02;
  localparam logic [7:0] CMD_ENTRY_STORE  = 8'h03;
  localparam logic [7:0] CMD_BYTE_SEEK    = 8'h04;
  localparam logic [7:0] CMD_BYTE_READ    = 8'h05;
  localparam logic [7:0] CMD_READ_CONT    = 8'h06;
  localparam logic [7:0] CMD_BUF_READOUT  = 8'h07;
  localparam logic [7:0] CMD_BUF_PATCH    = 8'h08;
  localparam logic [7:0] CMD_STATUS_FETCH = 8'h09;
  // Status codes
  localparam logic [7:0] STAT_DONE     = 8'h01;
  localparam logic [7:0] STAT_READ_RDY = 8'h02;
  localparam logic [7:0] STAT_ERR      = 8'h03;
  // Close parameter and entry index values
  localparam logic [7:0] CLOSE_UPDATE = 8'h01;
  localparam logic [7:0] ENTRY_MAX    = 8'h0F;
  localparam logic [7:0] ENTRY_OPEN   = 8'hFF;
  // Cache geometry: 16 entries of 32 bytes
  localparam int         CACHE_BYTES  = 512;
  localparam logic [8:0] CACHE_LAST   = 9'h1FF;
  localparam logic [7:0] ENTRY_LEN    = 8'h20;
  localparam logic [7:0] LBA_LEN      = 8'h04;
  localparam int         SECTOR_SHIFT = 9;
  localparam logic [31:0] LBA_AT_END  = 32'hFFFFFFFF;
  // Byte-read block window
  localparam int          BLK_BITS = 6;
  localparam logic [15:0] BLK_MAX  = 16'h0040;
  localparam int          FIFO_DEPTH = 2;
  localparam logic [1:0]  FIFO_FULL  = 2'h2;
  // Reset values
  localparam logic [7:0]  STAT_RST = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h00000000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_PARAM = 3'b001,
    ST_PATCH = 3'b011,
    ST_STEP  = 3'b010,
    ST_OUT   = 3'b110,
    ST_LOAD  = 3'b111,
    ST_SAVE  = 3'b101
  } fach_state_e;

  typedef enum logic [1:0] {
    SRC_NONE  = 2'b00,
    SRC_ENTRY = 2'b01,
    SRC_LBA   = 2'b10,
    SRC_DATA  = 2'b11
  } fach_src_e;

  typedef struct packed {
    logic       is_cmd;
    logic [7:0] data;
  } fach_hbyte_s;

  typedef struct packed {
    logic        we;
    logic        dir;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } fach_med_s;
endpackage

// [design/fach_file_access.sv]
`timescale 1ns/1ps
`default_nettype none
module fach_file_access
  import fach_pkg::*;
(
  input  wire logic        MCLK,          // System clock
  input  wire logic        RST_N,         // Synchronous reset
  input  wire fach_hbyte_s HOST_IN,       // Command or parameter byte
  input  wire logic        HOST_VALID,    // Host byte offered
  output logic             HOST_READY,    // Host byte accepted
  output logic [7:0]       HOST_RD_DATA,  // Readout byte
  output logic             HOST_RD_VALID, // Readout byte available
  input  wire logic        HOST_RD_READY, // Host takes readout byte
  output logic             INT_N,         // Pending status
  input  wire logic        FILE_OPENED,   // Open or create done pulse
  input  wire logic [31:0] FILE_SIZE,     // Size of opened file
  input  wire logic [31:0] FILE_LBA,      // First sector of opened file
  input  wire logic [3:0]  FILE_SLOT,     // Cache slot of opened file
  input  wire logic        SECTOR_USED,   // Sector command touched file
  output var fach_med_s    MED_OUT,       // Medium access attributes
  output logic             MED_REQ,       // Medium byte request
  input  wire logic        MED_ACK,       // Medium byte done
  input  wire logic [7:0]  MED_RDATA,     // Medium read byte
  output logic             LEN_UPD,       // Store length pulse
  output logic [31:0]      LEN_VALUE,     // Length to store
  output logic             ROOT_RELEASE   // Close pulse
);
  fach_state_e state_reg, exec_state;
  fach_src_e   src_reg;
  logic [7:0]  cmd_reg, exec_cmd, stat_reg, evt_stat, out_len, push_byte;
  logic [2:0]  pcnt_reg;
  logic [31:0] par_reg, par_next, ptr_reg, size_reg, lba0_reg, lba_res_reg;
  logic [31:0] mptr_reg, rem_file, seek_ptr, seek_lba;
  logic [32:0] seek_sum;
  logic [15:0] req_reg, rem16, win, blk;
  logic [7:0]  blk_len_reg, patch_cnt_reg, wdata_reg;
  logic [4:0]  patch_ofs_reg;
  logic [3:0]  sel_reg;
  logic [8:0]  xfer_reg, out_last;
  logic        sec_mode_reg, rd_active_reg, int_pend_reg, out_stat_reg;
  logic        take, new_cmd, exec, evt_int, step_done, push, pop, med_last;
  logic [7:0]  cache [CACHE_BYTES];
  logic [7:0]  fifo_mem [FIFO_DEPTH];
  logic        fifo_wp_reg, fifo_rp_reg;
  logic [1:0]  fifo_cnt_reg;

  function automatic logic [2:0] param_need(input logic [7:0] c);
    case (c)
      CMD_FILE_CLOSE, CMD_ENTRY_FETCH: param_need = 3'h1;
      CMD_BYTE_READ, CMD_BUF_PATCH:    param_need = 3'h2;
      CMD_BYTE_SEEK:                   param_need = 3'h4;
      default:                         param_need = 3'h0;
    endcase
  endfunction

  // Host byte intake and command completion
  assign HOST_READY = (state_reg == ST_IDLE) || (state_reg == ST_PARAM) ||
                      (state_reg == ST_PATCH);
  assign take       = HOST_VALID && HOST_READY;
  assign new_cmd    = take && HOST_IN.is_cmd;
  assign par_next   = {HOST_IN.data, par_reg[31:8]};
  always_comb begin
    exec = 1'b0;
    exec_cmd = cmd_reg;
    if (new_cmd && param_need(HOST_IN.data) == 3'h0) begin
      exec = 1'b1;
      exec_cmd = HOST_IN.data;
    end else if (take && !HOST_IN.is_cmd && state_reg == ST_PARAM &&
                 pcnt_reg == param_need(cmd_reg) - 3'h1) begin
      exec = 1'b1;
    end
    case (exec_cmd)
      CMD_BYTE_READ:    exec_state = ST_STEP;
      CMD_READ_CONT:    exec_state = rd_active_reg ? ST_STEP : ST_IDLE;
      CMD_ENTRY_STORE:  exec_state = ST_SAVE;
      CMD_BUF_READOUT,
      CMD_STATUS_FETCH: exec_state = ST_OUT;
      CMD_BUF_PATCH:    exec_state = (HOST_IN.data != 8'h00) ? ST_PATCH : ST_IDLE;
      default:          exec_state = ST_IDLE;
    endcase
  end

  // Seek target clamped at file end, and its sector number
  always_comb begin
    seek_sum = {1'b0, ptr_reg} + {1'b0, par_next};
    seek_ptr = (seek_sum > {1'b0, size_reg}) ? size_reg : seek_sum[31:0];
    seek_lba = (seek_ptr >= size_reg) ? LBA_AT_END :
               lba0_reg + {9'h000, seek_ptr[31:SECTOR_SHIFT]};
  end

  // Block sizing: request, rest of file and the buffer window all limit it
  always_comb begin
    rem_file  = size_reg - ptr_reg;
    rem16     = (|rem_file[31:16]) ? 16'hFFFF : rem_file[15:0];
    win       = BLK_MAX - 16'(ptr_reg[BLK_BITS-1:0]);
    blk       = (req_reg < rem16) ? req_reg : rem16;
    blk       = (blk < win) ? blk : win;
    step_done = (rem_file == WORD_RST) || (req_reg == 16'h0000);
  end

  // Events that raise the interrupt and their status code
  always_comb begin
    evt_int  = 1'b0;
    evt_stat = STAT_DONE;
    if (state_reg == ST_STEP) begin
      evt_int  = 1'b1;
      evt_stat = step_done ? STAT_DONE : STAT_READ_RDY;
    end else if (state_reg == ST_SAVE && MED_ACK && med_last) begin
      evt_int  = 1'b1;
    end else if (exec) begin
      case (exec_cmd)
        CMD_FILE_CLOSE, CMD_BYTE_SEEK: evt_int = 1'b1;
        CMD_ENTRY_FETCH: begin
          evt_int  = 1'b1;
          evt_stat = (par_next[31:24] <= ENTRY_MAX || par_next[31:24] == ENTRY_OPEN) ?
                     STAT_DONE : STAT_ERR;
        end
        CMD_READ_CONT: begin
          evt_int  = !rd_active_reg;
          evt_stat = STAT_ERR;
        end
        default: evt_int = 1'b0;
      endcase
    end
  end

  // Readout stream: length byte first, then the result bytes; a status fetch sends the status byte alone
  assign med_last = (xfer_reg == CACHE_LAST);
  always_comb begin
    case (src_reg)
      SRC_ENTRY: out_len = ENTRY_LEN;
      SRC_LBA:   out_len = LBA_LEN;
      SRC_DATA:  out_len = blk_len_reg;
      default:   out_len = 8'h00;
    endcase
    out_last  = out_stat_reg ? 9'h000 : {1'b0, out_len};
    push      = 1'b0;
    push_byte = out_len;
    if (state_reg == ST_OUT && fifo_cnt_reg != FIFO_FULL) begin
      if (out_stat_reg) begin
        push = 1'b1;
        push_byte = stat_reg;
      end else if (xfer_reg == 9'h000) begin
        push = 1'b1;
      end else begin
        case (src_reg)
          SRC_ENTRY: push_byte = cache[{sel_reg, 5'(xfer_reg - 9'h001)}];
          SRC_LBA:   push_byte = lba_res_reg[{2'(xfer_reg - 9'h001), 3'b000} +: 8];
          default:   push_byte = MED_RDATA;
        endcase
        push = (src_reg == SRC_DATA) ? MED_ACK : 1'b1;
      end
    end
  end

  // Medium port: cache load, cache store, read-block bytes
  assign MED_REQ = (state_reg == ST_LOAD) || (state_reg == ST_SAVE) ||
                   (state_reg == ST_OUT && !out_stat_reg && src_reg == SRC_DATA &&
                    xfer_reg != 9'h000 && fifo_cnt_reg != FIFO_FULL);
  // Block byte n sits at base plus n-1, since count 0 is the length byte
  assign MED_OUT = '{we: state_reg == ST_SAVE, dir: state_reg != ST_OUT,
                     addr: (state_reg == ST_OUT) ?
                           mptr_reg + {23'h000000, xfer_reg} - 32'h00000001 :
                           {23'h000000, xfer_reg},
                     wdata: wdata_reg};

  // Main sequencer; a file open preempts anything in flight
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state_reg <= ST_IDLE;
    end else if (FILE_OPENED) begin
      state_reg <= ST_LOAD;
    end else if (exec) begin
      state_reg <= exec_state;
    end else if (new_cmd) begin
      state_reg <= ST_PARAM;
    end else begin
      unique case (state_reg)
        ST_PATCH: if (take && patch_cnt_reg == 8'h01) state_reg <= ST_IDLE;
        ST_STEP:  state_reg <= ST_IDLE;
        ST_LOAD,
        ST_SAVE:  if (MED_ACK && med_last) state_reg <= ST_IDLE;
        ST_OUT:   if (push && xfer_reg == out_last) state_reg <= ST_IDLE;
        ST_IDLE,
        ST_PARAM: state_reg <= state_reg;
        default:  state_reg <= ST_IDLE;
      endcase
    end
  end

  // Command and parameter capture
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      cmd_reg  <= 8'h00;
      pcnt_reg <= 3'h0;
      par_reg  <= WORD_RST;
    end else if (new_cmd) begin
      cmd_reg  <= HOST_IN.data;
      pcnt_reg <= 3'h0;
      par_reg  <= WORD_RST;
    end else if (take && state_reg == ST_PARAM) begin
      pcnt_reg <= pcnt_reg + 3'h1;
      par_reg  <= par_next;
    end
  end

  // File pointer, byte-read progress and result selection
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ptr_reg <= WORD_RST;
      size_reg <= WORD_RST;
      lba0_reg <= WORD_RST;
      lba_res_reg <= WORD_RST;
      sec_mode_reg <= 1'b0;
      rd_active_reg <= 1'b0;
      req_reg <= 16'h0000;
      blk_len_reg <= 8'h00;
      mptr_reg <= WORD_RST;
      sel_reg <= 4'h0;
      src_reg <= SRC_NONE;
    end else if (FILE_OPENED) begin
      ptr_reg <= WORD_RST;
      size_reg <= FILE_SIZE;
      lba0_reg <= FILE_LBA;
      sec_mode_reg <= 1'b0;
      rd_active_reg <= 1'b0;
      src_reg <= SRC_NONE;
    end else if (state_reg == ST_STEP) begin
      if (step_done) begin
        rd_active_reg <= 1'b0;
      end else begin
        req_reg <= req_reg - blk;
        ptr_reg <= ptr_reg + {16'h0000, blk};
        mptr_reg <= lba0_reg + ptr_reg;
        blk_len_reg <= blk[7:0];
        src_reg <= SRC_DATA;
      end
    end else begin
      if (SECTOR_USED) sec_mode_reg <= 1'b1;
      if (new_cmd && HOST_IN.data != CMD_READ_CONT && HOST_IN.data != CMD_BUF_READOUT &&
          HOST_IN.data != CMD_STATUS_FETCH) begin
        rd_active_reg <= 1'b0;
      end
      if (exec && exec_cmd == CMD_BYTE_SEEK) begin
        ptr_reg <= seek_ptr;
        lba_res_reg <= seek_lba;
        src_reg <= SRC_LBA;
        sec_mode_reg <= 1'b0;
      end
      if (exec && exec_cmd == CMD_BYTE_READ) begin
        req_reg <= par_next[31:16];
        rd_active_reg <= 1'b1;
        sec_mode_reg <= 1'b0;
      end
      if (exec && exec_cmd == CMD_ENTRY_FETCH && evt_stat == STAT_DONE) begin
        sel_reg <= (par_next[31:24] == ENTRY_OPEN) ? FILE_SLOT : par_next[27:24];
        src_reg <= SRC_ENTRY;
      end
    end
  end

  // Close: length store request and directory release
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      LEN_UPD <= 1'b0;
      LEN_VALUE <= WORD_RST;
      ROOT_RELEASE <= 1'b0;
    end else begin
      LEN_UPD <= exec && exec_cmd == CMD_FILE_CLOSE && par_next[31:24] == CLOSE_UPDATE;
      ROOT_RELEASE <= exec && exec_cmd == CMD_FILE_CLOSE;
      if (sec_mode_reg) begin
        LEN_VALUE <= {23'(size_reg[31:9] + 23'(|size_reg[8:0])), 9'h000};
      end else begin
        LEN_VALUE <= size_reg;
      end
    end
  end

  // Transfer counters, patch position and store data prefetch
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      xfer_reg <= 9'h000;
      out_stat_reg <= 1'b0;
      patch_ofs_reg <= 5'h00;
      patch_cnt_reg <= 8'h00;
      wdata_reg <= 8'h00;
    end else if (FILE_OPENED || exec) begin
      xfer_reg <= 9'h000;
      out_stat_reg <= exec && exec_cmd == CMD_STATUS_FETCH;
      patch_ofs_reg <= par_reg[28:24];
      patch_cnt_reg <= HOST_IN.data;
      wdata_reg <= cache[0];
    end else if (push || ((state_reg == ST_LOAD || state_reg == ST_SAVE) && MED_ACK)) begin
      xfer_reg <= xfer_reg + 9'h001;
      wdata_reg <= cache[xfer_reg + 9'h001];
    end else if (take && state_reg == ST_PATCH) begin
      patch_ofs_reg <= patch_ofs_reg + 5'h01;
      patch_cnt_reg <= patch_cnt_reg - 8'h01;
    end
  end

  // Entry cache: filled from the medium, patched by the host
  always_ff @(posedge MCLK) begin
    if (state_reg == ST_LOAD && MED_ACK) begin
      cache[xfer_reg] <= MED_RDATA;
    end else if (take && !HOST_IN.is_cmd && state_reg == ST_PATCH) begin
      cache[{sel_reg, patch_ofs_reg}] <= HOST_IN.data;
    end
  end

  // Interrupt holds until the host fetches status; a new event beats the clear
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      int_pend_reg <= 1'b0;
      stat_reg <= STAT_RST;
    end else if (evt_int) begin
      int_pend_reg <= 1'b1;
      stat_reg <= evt_stat;
    end else if (exec && exec_cmd == CMD_STATUS_FETCH) begin
      int_pend_reg <= 1'b0;
    end
  end
  assign INT_N = !int_pend_reg;

  // Two-entry readout buffer; a host stall holds the stream, nothing drops
  assign pop           = HOST_RD_VALID && HOST_RD_READY;
  assign HOST_RD_VALID = (fifo_cnt_reg != 2'h0);
  assign HOST_RD_DATA  = fifo_mem[fifo_rp_reg];
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      fifo_wp_reg <= 1'b0;
      fifo_rp_reg <= 1'b0;
      fifo_cnt_reg <= 2'h0;
    end else begin
      if (push) begin
        fifo_mem[fifo_wp_reg] <= push_byte;
        fifo_wp_reg <= !fifo_wp_reg;
      end
      if (pop) fifo_rp_reg <= !fifo_rp_reg;
      fifo_cnt_reg <= fifo_cnt_reg + 2'(push) - 2'(pop);
    end
  end
endmodule
`default_nettype wire

// [test/fach_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module fach_sva
  import fach_pkg::*;
(
  input wire logic        MCLK,          // Clock
  input wire logic        RST_N,         // Sync reset
  input wire fach_hbyte_s HOST_IN,       // Host byte
  input wire logic        HOST_VALID,    // Host byte offered
  input wire logic        HOST_READY,    // Host byte accepted
  input wire logic [7:0]  HOST_RD_DATA,  // Readout byte
  input wire logic        HOST_RD_VALID, // Readout valid
  input wire logic        HOST_RD_READY, // Readout taken
  input wire logic        INT_N,         // Pending status
  input wire logic        FILE_OPENED,   // Open pulse
  input wire fach_med_s   MED_OUT,       // Medium attributes
  input wire logic        MED_REQ,       // Medium request
  input wire logic        MED_ACK        // Medium done
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // Status fetch taken at this edge
  wire logic fetch = HOST_VALID && HOST_READY && HOST_IN.is_cmd &&
                     HOST_IN.data == CMD_STATUS_FETCH;
  AST_REQ_HOLD: assert property (MED_REQ && !MED_ACK |=> MED_REQ && $stable(MED_OUT))
    else $error("medium request dropped or changed before ack");
  AST_OPEN_LOAD: assert property (FILE_OPENED |=> MED_REQ && MED_OUT.dir && !MED_OUT.we
    && MED_OUT.addr == 32'h00000000) else $error("cache load did not start at byte 0");
  AST_LOAD_END: assert property (MED_REQ && MED_ACK && MED_OUT.dir
    && MED_OUT.addr == 32'h000001FF |=> !MED_REQ)
    else $error("directory transfer ran past 512 bytes");
  AST_DIR_RANGE: assert property (MED_REQ && MED_OUT.dir |-> MED_OUT.addr <= 32'h000001FF)
    else $error("directory address out of cache");
  AST_BUSY: assert property (MED_REQ |-> !HOST_READY)
    else $error("host byte accepted while busy");
  AST_INT_HOLD: assert property (!INT_N && !fetch |=> !INT_N)
    else $error("interrupt lost early");
  AST_INT_CLR: assert property (!INT_N && fetch |=> INT_N)
    else $error("interrupt not cleared");
  // Status byte is pushed the cycle after the fetch and shows one cycle later
  AST_STAT_NEXT: assert property (fetch |-> ##2 HOST_RD_VALID)
    else $error("status byte late");
  AST_RD_HOLD: assert property (HOST_RD_VALID && !HOST_RD_READY |=> HOST_RD_VALID
    && $stable(HOST_RD_DATA)) else $error("readout byte changed before taken");
endmodule
bind fach_file_access fach_sva fach_sva_inst (.MCLK(MCLK), .RST_N(RST_N), .HOST_IN(HOST_IN),
  .HOST_VALID(HOST_VALID), .HOST_READY(HOST_READY), .HOST_RD_DATA(HOST_RD_DATA),
  .HOST_RD_VALID(HOST_RD_VALID), .HOST_RD_READY(HOST_RD_READY), .INT_N(INT_N),
  .FILE_OPENED(FILE_OPENED), .MED_OUT(MED_OUT), .MED_REQ(MED_REQ), .MED_ACK(MED_ACK));
`default_nettype wire

// [test/fach_med_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fach_med_model
  import fach_pkg::*;
(
  input  wire logic      MCLK,      // Clock
  input  wire fach_med_s MED_OUT,   // Access attributes
  input  wire logic      MED_REQ,   // Byte request
  output logic           MED_ACK,   // Byte done
  output logic [7:0]     MED_RDATA  // Read byte
);
  logic a;
  initial begin
    MED_ACK = 1'b0;
    MED_RDATA = 8'h00;
  end
  // Random latency; between bytes the data lines show junk so stale data is caught
  always @(negedge MCLK) begin
    a = MED_REQ && ($urandom_range(1) == 1);
    MED_ACK <= a;
    MED_RDATA <= !a ? ~MED_RDATA : MED_OUT.dir ? MED_OUT.addr[7:0] ^ 8'h5A
                 : MED_OUT.addr[7:0] + MED_OUT.addr[15:8];
  end
endmodule
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb
  import fach_pkg::*;
;
  logic mclk = 1'b0, rst_n = 1'b0, hv = 1'b0, rrdy = 1'b0, fo = 1'b0, su = 1'b0;
  fach_hbyte_s hin = '0;
  logic [31:0] fsz = '0, lba = '0, ptr, lenv;
  logic [3:0] slot = '0;
  logic hrdy, rval, int_n, mreq, mack, lupd, rrel;
  logic [7:0] rdat, mdat, s, n, v;
  logic [31:0] lval;
  fach_med_s mout;
  logic [7:0] wmem [512];
  int miscompares = 0, compares = 0, nacc = 0, nwr = 0, nlen = 0, nrel = 0, i, k;
  fach_file_access fach_file_access_inst (.MCLK(mclk), .RST_N(rst_n), .HOST_IN(hin),
    .HOST_VALID(hv), .HOST_READY(hrdy), .HOST_RD_DATA(rdat), .HOST_RD_VALID(rval),
    .HOST_RD_READY(rrdy), .INT_N(int_n), .FILE_OPENED(fo), .FILE_SIZE(fsz), .FILE_LBA(lba),
    .FILE_SLOT(slot), .SECTOR_USED(su), .MED_OUT(mout), .MED_REQ(mreq), .MED_ACK(mack),
    .MED_RDATA(mdat), .LEN_UPD(lupd), .LEN_VALUE(lval), .ROOT_RELEASE(rrel));
  fach_med_model fach_med_model_inst (.MCLK(mclk), .MED_OUT(mout), .MED_REQ(mreq),
    .MED_ACK(mack), .MED_RDATA(mdat));
  always #5 mclk = ~mclk;
  // Monitor of medium traffic and close pulses
  always @(posedge mclk) begin
    if (mreq && mack) begin
      nacc++;
      if (mout.we) begin
        nwr++;
        wmem[mout.addr[8:0]] = mout.wdata;
      end
    end
    if (lupd) begin
      nlen++;
      lenv = lval;
    end
    if (rrel) nrel++;
  end
  function automatic logic [7:0] mb(input logic d, input logic [31:0] a);
    return d ? a[7:0] ^ 8'h5A : a[7:0] + a[15:8];
  endfunction
  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] sn, input logic [31:0] ex);
    compares++;
    if (sn !== ex) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  // Host byte: offered at a falling edge only while ready, dropped one edge later
  task automatic put(input logic c, input logic [7:0] d);
    @(negedge mclk);
    while (hrdy !== 1'b1) @(negedge mclk);
    hv = 1'b1;
    hin = '{c, d};
    @(negedge mclk);
    hv = 1'b0;
  endtask
  task automatic get(output logic [7:0] b);
    @(negedge mclk);
    while (rval !== 1'b1) @(negedge mclk);
    rrdy = 1'b1;
    b = rdat;
    @(negedge mclk);
    rrdy = 1'b0;
  endtask
  task automatic stat(output logic [7:0] st);
    @(negedge mclk);
    while (int_n !== 1'b0) @(negedge mclk);
    put(1'b1, CMD_STATUS_FETCH);
    get(st);
    chk("int_n", int_n, 1'b1);
  endtask
  task automatic cmd1(input logic [7:0] c, input logic [7:0] p);
    put(1'b1, c);
    put(1'b0, p);
    stat(s);
  endtask
  task automatic open(input logic [31:0] sz);
    @(negedge mclk);
    fsz = sz;
    lba = $urandom;
    slot = 4'($urandom);
    fo = 1'b1;
    ptr = 0;
    nacc = 0;
    @(negedge mclk);
    fo = 1'b0;
    while (mreq !== 1'b1) @(negedge mclk);
    while (mreq !== 1'b0) @(negedge mclk);
    chk("load count", nacc, CACHE_BYTES);
  endtask
  task automatic seek(input logic [31:0] off);
    logic [32:0] t;
    logic [31:0] w;
    put(1'b1, CMD_BYTE_SEEK);
    for (k = 0; k < 4; k++) put(1'b0, off[8*k+:8]);
    t = ptr + off;
    ptr = (t > fsz) ? fsz : t[31:0];
    stat(s);
    chk("seek status", s, STAT_DONE);
    put(1'b1, CMD_BUF_READOUT);
    get(n);
    chk("lba len", n, LBA_LEN);
    for (k = 0; k < 4; k++) get(w[8*k+:8]);
    chk("lba", w, ptr == fsz ? LBA_AT_END : lba + (ptr >> SECTOR_SHIFT));
  endtask
  // Byte read loop, summing blocks as a host would
  task automatic rd(input logic [15:0] c);
    logic [31:0] rem, b, tot;
    put(1'b1, CMD_BYTE_READ);
    put(1'b0, c[7:0]);
    put(1'b0, c[15:8]);
    rem = c;
    tot = 0;
    for (i = 0; i < 40; i++) begin
      stat(s);
      chk("read status", s, (rem == 0 || ptr == fsz) ? STAT_DONE : STAT_READ_RDY);
      if (s !== STAT_READ_RDY) break;
      b = 32'h40 - ptr[5:0];
      if (rem < b) b = rem;
      if (fsz - ptr < b) b = fsz - ptr;
      put(1'b1, CMD_BUF_READOUT);
      get(n);
      chk("block len", n, b);
      for (k = 0; k < n; k++) begin
        get(v);
        chk("block data", v, mb(1'b0, lba + ptr + k));
      end
      ptr += b;
      rem -= b;
      tot += n;
      put(1'b1, CMD_READ_CONT);
    end
    chk("read total", tot, (c < fsz - ptr + tot) ? c : tot);
  endtask
  // Whole run needs some ten thousand cycles; allow three times that
  initial begin
    #300000;
    miscompares++;
    final_report();
  end
  initial begin
    void'($urandom(9));
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    chk("reset int", int_n, 1'b1);
    chk("reset rval", rval, 1'b0);
    open(32'd300 + $urandom_range(200));
    // Every cached entry, the open file, then an index out of range
    for (i = 0; i < 18; i++) begin
      cmd1(CMD_ENTRY_FETCH, i < 16 ? i[7:0] : i == 16 ? ENTRY_OPEN : 8'h10);
      chk("fetch status", s, i < 17 ? STAT_DONE : STAT_ERR);
      if (i == 17) break;
      put(1'b1, CMD_BUF_READOUT);
      get(n);
      chk("entry len", n, ENTRY_LEN);
      for (k = 0; k < 32; k++) begin
        get(v);
        chk("entry byte", v, mb(1'b1, (i < 16 ? i : slot) * 32 + k));
      end
    end
    cmd1(CMD_ENTRY_FETCH, 8'h05);
    put(1'b1, CMD_BUF_PATCH);
    put(1'b0, 8'h18);
    put(1'b0, 8'h02);
    put(1'b0, 8'hC3);
    put(1'b0, 8'h3C);
    nwr = 0;
    put(1'b1, CMD_ENTRY_STORE);
    stat(s);
    chk("store status", s, STAT_DONE);
    chk("store count", nwr, CACHE_BYTES);
    chk("date lo", wmem[184], 8'hC3);
    chk("date hi", wmem[185], 8'h3C);
    chk("kept byte", wmem[186], mb(1'b1, 186));
    seek($urandom_range(150));
    seek($urandom_range(400));
    seek(32'h0FFFFFFF);
    open(32'd300 + $urandom_range(200));
    seek(fsz - 90);
    rd(16'h0000);
    rd(16'($urandom_range(30, 80)));
    rd(16'h00C8);
    put(1'b1, CMD_READ_CONT);
    stat(s);
    chk("idle continue", s, STAT_ERR);
    // Close with byte-mode update, sector-mode update, and no update
    for (i = 0; i < 3; i++) begin
      // The file read above is left without a close before the next open
      open(32'd300 + $urandom_range(200));
      if (i == 0) seek(32'h0);
      if (i == 1) begin
        @(negedge mclk);
        su = 1'b1;
        @(negedge mclk);
        su = 1'b0;
      end
      nlen = 0;
      nrel = 0;
      cmd1(CMD_FILE_CLOSE, i == 2 ? 8'h00 : CLOSE_UPDATE);
      chk("close status", s, STAT_DONE);
      chk("release", nrel, 1);
      chk("len upd", nlen, i == 2 ? 0 : 1);
      if (i < 2) chk("len", lenv, i == 0 ? fsz : (fsz + 511) & 32'hFFFFFE00);
    end
    final_report();
  end
endmodule
`default_nettype wire
